//--- hw/cbe_pkg.sv
`default_nettype none
package cbe_pkg;
   // Program counter and displacement widths
   localparam int PC_W = 16;
   localparam int OFS_W = 7;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] PC_ONE = 16'h0001;
   // Cycle costs of a branch
   localparam logic [1:0] CYC_NOT_TAKEN = 2'h1;
   localparam logic [1:0] CYC_TAKEN = 2'h2;

   // Branch condition selector
   typedef enum logic [3:0] {
      branch_none = 4'h0,
      branch_unsigned_lower = 4'h1,
      branch_on_negative = 4'h2,
      branch_on_plus = 4'h3,
      branch_signed_ge = 4'h4,
      branch_signed_less = 4'h5,
      branch_half_carry_set = 4'h6,
      branch_half_carry_clear = 4'h7,
      branch_transfer_bit_set = 4'h8,
      branch_transfer_bit_clear = 4'h9,
      branch_overflow_set = 4'hA,
      branch_carry_clear = 4'hB,
      branch_unsigned_same_or_higher = 4'hC
   } cbe_cond_type;

   // Status flags as held in the status register
   typedef struct packed {
      logic t;
      logic h;
      logic v;
      logic n;
      logic c;
   } cbe_flags_type;

   // Decoded branch request
   typedef struct packed {
      logic valid;
      cbe_cond_type cond;
      logic [6:0] offset;
   } cbe_req_type;

   // Sequencer states, Gray along the taken path
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SECOND = 2'b01
   } cbe_state_type;
endpackage
`default_nettype wire

//--- hw/conditional_branch_evaluator.sv
// Contract
// [RULE_01] Unsigned-lower branch taken exactly when carry is one.
// [RULE_02] Negative branch taken exactly when negative flag is one.
// [RULE_03] Plus branch taken exactly when negative flag is zero.
// [RULE_04] Signed greater-or-equal taken when negative xor overflow is zero.
// [RULE_05] Signed less-than taken when negative xor overflow is one.
// [RULE_06] Half-carry-set branch taken when half carry is one.
// [RULE_07] Half-carry-clear branch taken when half carry is zero.
// [RULE_08] Transfer-bit-set branch taken when transfer bit is one.
// [RULE_09] Transfer-bit-clear branch taken when transfer bit is zero.
// [RULE_10] Overflow-set branch taken when overflow flag is one.
// [RULE_11] Carry-clear branch taken when carry is zero.
// [RULE_12] Same-or-higher branch taken when carry is zero, like carry-clear.
// [RULE_13] Taken branch loads program counter with itself plus offset plus one.
// [RULE_14] Flags untouched; one cycle not taken, two cycles taken.
// [RULE_15] Offset is signed, sign-extended to program counter width.
// [RULE_16] Flags tested are the committed status register values.
`timescale 1ns/10ps
`default_nettype none
module conditional_branch_evaluator (
   input wire logic ref_clk,
   input wire logic rst,
   input wire cbe_pkg::cbe_req_type req,
   input wire cbe_pkg::cbe_flags_type flags,
   input wire logic [15:0] pcIn,
   output logic [15:0] pcOut,
   output logic pcLoad,
   output logic taken,
   output logic busy,
   output logic done,
   output logic [1:0] cycles,
   output var cbe_pkg::cbe_flags_type flagsOut
);
   import cbe_pkg::*;

   cbe_state_type state_ff;
   cbe_state_type nxt_state;
   logic [15:0] pcOut_ff;
   logic pcLoad_ff;
   logic taken_ff;
   logic busy_ff;
   logic done_ff;
   logic [1:0] cycles_ff;
   cbe_flags_type flagsOut_ff;

   // Condition decode straight from the committed flags
   wire logic nxorV = flags.n ^ flags.v;
   wire logic condTrue =
      (req.cond == branch_unsigned_lower) ? flags.c :          // RULE_01
      (req.cond == branch_on_negative) ? flags.n :             // RULE_02
      (req.cond == branch_on_plus) ? ~flags.n :                // RULE_03
      (req.cond == branch_signed_ge) ? ~nxorV :                // RULE_04
      (req.cond == branch_signed_less) ? nxorV :               // RULE_05
      (req.cond == branch_half_carry_set) ? flags.h :          // RULE_06
      (req.cond == branch_half_carry_clear) ? ~flags.h :       // RULE_07
      (req.cond == branch_transfer_bit_set) ? flags.t :        // RULE_08
      (req.cond == branch_transfer_bit_clear) ? ~flags.t :     // RULE_09
      (req.cond == branch_overflow_set) ? flags.v :            // RULE_10
      (req.cond == branch_carry_clear) ? ~flags.c :            // RULE_11
      (req.cond == branch_unsigned_same_or_higher) ? ~flags.c : // RULE_12
      1'b0;
   // Requests during the second cycle are ignored; the core stalls then
   wire logic accept = req.valid && (state_ff == ST_IDLE);
   wire logic takeNow = accept && condTrue;
   // Sign extension lets branches run backward as well as forward
   wire logic [15:0] offsetExt = {{(PC_W - OFS_W){req.offset[6]}}, req.offset}; // RULE_15
   wire logic [15:0] target = pcIn + offsetExt + PC_ONE; // RULE_13

   // Taken branch spends one extra cycle in ST_SECOND
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (takeNow) begin
               nxt_state = ST_SECOND; // RULE_14
            end
         end
         ST_SECOND: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // State and answer registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_IDLE;
         pcOut_ff <= PC_RESET;
         pcLoad_ff <= 1'b0;
         taken_ff <= 1'b0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         cycles_ff <= 2'h0;
      end else begin
         state_ff <= nxt_state;
         pcLoad_ff <= takeNow;
         taken_ff <= takeNow;
         busy_ff <= takeNow;
         // Done marks the last cycle of the instruction
         done_ff <= (accept && !condTrue) || (state_ff == ST_SECOND);
         if (takeNow) begin
            pcOut_ff <= target; // RULE_13
         end
         if (accept) begin
            cycles_ff <= condTrue ? CYC_TAKEN : CYC_NOT_TAKEN; // RULE_14
         end
      end
   end

   // Flags pass through unchanged, sampled from the committed register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flagsOut_ff <= '0;
      end else begin
         flagsOut_ff <= flags; // RULE_14 RULE_16
      end
   end

   assign pcOut = pcOut_ff;
   assign pcLoad = pcLoad_ff;
   assign taken = taken_ff;
   assign busy = busy_ff;
   assign done = done_ff;
   assign cycles = cycles_ff;
   assign flagsOut = flagsOut_ff;

   // Helper: expected target computed independently
   wire logic [15:0] expTarget = pcIn + {{9{req.offset[6]}}, req.offset} + 16'h0001;

   property p_target;
      @(posedge ref_clk) disable iff (rst)
      (req.valid && state_ff == ST_IDLE && condTrue) |=> (pcLoad && pcOut == $past(expTarget));
   endproperty
   a_target: assert property (p_target) else $error("Taken branch target wrong"); // RULE_13

   property p_lower;
      @(posedge ref_clk) disable iff (rst)
      (accept && req.cond == branch_unsigned_lower) |=> (taken == $past(flags.c));
   endproperty
   a_lower: assert property (p_lower) else $error("Lower branch decision wrong"); // RULE_01

   property p_neg;
      @(posedge ref_clk) disable iff (rst)
      (accept && (req.cond == branch_on_negative || req.cond == branch_on_plus))
         |=> (taken == ($past(flags.n) == ($past(req.cond) == branch_on_negative)));
   endproperty
   a_neg: assert property (p_neg) else $error("Sign branch decision wrong"); // RULE_02 RULE_03

   property p_signed;
      @(posedge ref_clk) disable iff (rst)
      (accept && (req.cond == branch_signed_ge || req.cond == branch_signed_less))
         |=> (taken == (($past(flags.n) ^ $past(flags.v)) == ($past(req.cond) == branch_signed_less)));
   endproperty
   a_signed: assert property (p_signed) else $error("Signed branch decision wrong"); // RULE_04 RULE_05

   property p_half;
      @(posedge ref_clk) disable iff (rst)
      (accept && (req.cond == branch_half_carry_set || req.cond == branch_half_carry_clear))
         |=> (taken == ($past(flags.h) == ($past(req.cond) == branch_half_carry_set)));
   endproperty
   a_half: assert property (p_half) else $error("Half carry branch decision wrong"); // RULE_06 RULE_07

   property p_tbit;
      @(posedge ref_clk) disable iff (rst)
      (accept && (req.cond == branch_transfer_bit_set || req.cond == branch_transfer_bit_clear))
         |=> (taken == ($past(flags.t) == ($past(req.cond) == branch_transfer_bit_set)));
   endproperty
   a_tbit: assert property (p_tbit) else $error("Transfer bit branch decision wrong"); // RULE_08 RULE_09

   property p_ovf;
      @(posedge ref_clk) disable iff (rst)
      (accept && req.cond == branch_overflow_set) |=> (taken == $past(flags.v));
   endproperty
   a_ovf: assert property (p_ovf) else $error("Overflow branch decision wrong"); // RULE_10

   property p_carry_clr;
      @(posedge ref_clk) disable iff (rst)
      (accept && (req.cond == branch_carry_clear || req.cond == branch_unsigned_same_or_higher))
         |=> (taken == !$past(flags.c));
   endproperty
   a_carry_clr: assert property (p_carry_clr) else $error("Carry clear branch decision wrong"); // RULE_11 RULE_12

   property p_cycles;
      @(posedge ref_clk) disable iff (rst)
      (accept && condTrue) |=> (cycles == 2'h2 && !done) ##1 (done && !busy);
   endproperty
   a_cycles: assert property (p_cycles) else $error("Taken branch cycle count wrong"); // RULE_14

   property p_flags;
      @(posedge ref_clk) disable iff (rst)
      1'b1 |=> (flagsOut == $past(flags));
   endproperty
   a_flags: assert property (p_flags) else $error("Flags altered"); // RULE_14 RULE_16

   property p_sext;
      @(posedge ref_clk) disable iff (rst)
      (accept && condTrue && req.offset[6])
         |=> (pcOut == $past(pcIn) - (16'h0080 - {9'h000, $past(req.offset)}) + 16'h0001);
   endproperty
   a_sext: assert property (p_sext) else $error("Backward offset not sign extended"); // RULE_15

   // Untaken branch finishes in its first cycle with no load
   property p_not_taken;
      @(posedge ref_clk) disable iff (rst)
      (accept && !condTrue) |=> (done && !taken && !pcLoad && !busy && cycles == CYC_NOT_TAKEN);
   endproperty
   a_not_taken: assert property (p_not_taken) else $error("Untaken branch answer wrong"); // RULE_14

   // Core stalls in the extra cycle; a request there must leave no trace
   property p_refused;
      @(posedge ref_clk) disable iff (rst)
      (state_ff == ST_SECOND) |=> (!taken && !pcLoad && !busy && $stable(pcOut));
   endproperty
   a_refused: assert property (p_refused) else $error("Request in extra cycle was answered"); // RULE_14

   // Empty condition code is a one-cycle no-op
   property p_none;
      @(posedge ref_clk) disable iff (rst)
      (accept && req.cond == branch_none) |=> (done && !taken);
   endproperty
   a_none: assert property (p_none) else $error("Empty condition branch taken"); // RULE_14

   c_taken: cover property (@(posedge ref_clk) disable iff (rst) accept && condTrue);
   c_not_taken: cover property (@(posedge ref_clk) disable iff (rst) accept && !condTrue);
   c_backward: cover property (@(posedge ref_clk) disable iff (rst) accept && condTrue && req.offset[6]);
   c_back2back: cover property (@(posedge ref_clk) disable iff (rst) (accept && !condTrue) ##1 accept);
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import cbe_pkg::*;
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   cbe_req_type req = '0;
   cbe_flags_type flags = '0;
   logic [15:0] pcIn = 16'h0000;
   logic [15:0] pcOut;
   logic pcLoad, taken, busy, done;
   logic [1:0] cycles;
   cbe_flags_type flagsOut;
   cbe_flags_type prevFlags = '0;
   logic [18:0] expQ[$];
   logic [18:0] note;
   logic [15:0] lfsr = 16'h7BD8;
   logic sawTk = 1'h0;
   int error_cnt = 0;
   int compares = 0;

   // Core clock, 100 ns period
   always #50 ref_clk = ~ref_clk;

   conditional_branch_evaluator i_conditional_branch_evaluator (.ref_clk(ref_clk), .rst(rst), .req(req),
      .flags(flags), .pcIn(pcIn), .pcOut(pcOut), .pcLoad(pcLoad), .taken(taken), .busy(busy), .done(done),
      .cycles(cycles), .flagsOut(flagsOut));

   // Pseudo-random source, fixed start
   function automatic logic [15:0] lfsrNext(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Reference decision per condition code
   function automatic logic condHolds(input cbe_cond_type c, input cbe_flags_type f);
      case (c)
         branch_unsigned_lower: return f.c;
         branch_on_negative: return f.n;
         branch_on_plus: return !f.n;
         branch_signed_ge: return !(f.n ^ f.v);
         branch_signed_less: return f.n ^ f.v;
         branch_half_carry_set: return f.h;
         branch_half_carry_clear: return !f.h;
         branch_transfer_bit_set: return f.t;
         branch_transfer_bit_clear: return !f.t;
         branch_overflow_set: return f.v;
         branch_carry_clear: return !f.c;
         branch_unsigned_same_or_higher: return !f.c;
         default: return 1'h0;
      endcase
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("errors %0d, compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // One branch; a taken one owns the next slot, which may carry a request the block must ignore
   task automatic issue(input cbe_cond_type c, input logic [6:0] ofs, input logic [15:0] pc, input logic refuse);
      logic tk;
      cbe_flags_type f;
      @(posedge ref_clk);
      lfsr = lfsrNext(lfsr);
      f = lfsr[4:0];
      tk = condHolds(c, f);
      req <= '{valid: 1'h1, cond: c, offset: ofs};
      flags <= f;
      pcIn <= pc;
      expQ.push_back({tk, tk ? CYC_TAKEN : CYC_NOT_TAKEN, pc + {{9{ofs[6]}}, ofs} + PC_ONE});
      if (tk) begin
         @(posedge ref_clk);
         req.valid <= refuse;
         pcIn <= ~pc;
         if (refuse) begin
            @(posedge ref_clk);
            req.valid <= 1'h0;
         end
      end
   endtask

   // Monitor at the falling edge, where registered outputs have settled
   always @(negedge ref_clk) begin
      if (!rst) begin
         chk($isunknown({taken, pcLoad, busy, done, cycles, pcOut}), 1'h0);
         chk(flagsOut, prevFlags);
         if (taken === 1'h1) begin
            chk({pcLoad, busy, done}, 3'h6);
            sawTk = 1'h1;
         end
         if (done === 1'h1) begin
            chk({taken, pcLoad, busy}, 3'h0);
            if (expQ.size() == 0) begin
               chk(32'h0000_0001, 32'h0000_0000);
            end else begin
               note = expQ.pop_front();
               chk(sawTk, note[18]);
               chk(cycles, note[17:16]);
               if (note[18]) begin
                  chk(pcOut, note[15:0]);
               end
            end
            sawTk = 1'h0;
         end
      end
      prevFlags = flags;
   end

   // Main sequence: edge offsets on every code, then random traffic
   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'h0;
      for (int i = 0; i < 13; i++) begin
         issue(cbe_cond_type'(4'(i)), 7'h3F, 16'hFFFF, 1'h0);
         issue(cbe_cond_type'(4'(i)), 7'h40, 16'h0040, 1'h1);
      end
      repeat (300) begin
         lfsr = lfsrNext(lfsr);
         issue(cbe_cond_type'(lfsr[7:4] % 4'hD), lfsr[14:8], {lfsr[3:0], lfsr[15:4]}, lfsr[0]);
      end
      @(posedge ref_clk);
      req.valid <= 1'h0;
      repeat (4) @(posedge ref_clk);
      chk(expQ.size(), 32'h0000_0000);
      wrap_up();
   end

   // Hang guard, about three times the longest possible run
   initial begin
      repeat (3000) @(posedge ref_clk);
      error_cnt++;
      wrap_up();
   end
endmodule
`default_nettype wire
